/* pkg/adc_pkg.sv */
// Shared constants for the converter control block
// Overview of operation
// - Selected hardware trigger sets the start bit
// - Channel codes route inputs 0-4, 8-19
// - Special codes route internal nodes, others none
// - Start bit starts, reads busy, self-clears
// - Enable bit powers the converter
// - Format one: right justified, upper zeros
// - Format zero: left justified, lower zeros
// - Clock field selects divider or RC oscillator
// - Reference field selects supply, pin, fixed
// - Unimplemented control bits read zero
// - Control registers reset to zero
// - Completion clears start, sets flag, loads result
// - Software clear aborts, loads filled partial result
// - Conversion lasts eleven and a half periods
`default_nettype none
package adc_pkg;
    // Byte offsets on the register bus
    localparam logic [7:0] OFF_CHAN_RUN = 8'h00;
    localparam logic [7:0] OFF_FMT_CLK = 8'h04;
    localparam logic [7:0] OFF_RES_HIGH = 8'h08;
    localparam logic [7:0] OFF_RES_LOW = 8'h0C;
    localparam logic [7:0] OFF_TRIG = 8'h10;
    localparam logic [7:0] OFF_INT_STATUS = 8'h14;
    localparam logic [7:0] OFF_INT_MASK = 8'h18;
    // Field positions
    localparam int EN_BIT = 0;
    localparam int GO_BIT = 1;
    localparam int CHAN_LSB = 2;
    localparam int FMT_BIT = 7;
    localparam int CLK_LSB = 4;
    localparam int TRIG_EN_BIT = 3;
    // Implemented-bit masks and reset values
    localparam logic [7:0] CHAN_RUN_MASK = 8'h7F;
    localparam logic [7:0] FMT_CLK_MASK = 8'hF3;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] RES_RESET = 8'h00;
    // Half conversion-period lengths in system clocks
    localparam logic [4:0] HALF_DIV2 = 5'h01;
    localparam logic [4:0] HALF_DIV4 = 5'h02;
    localparam logic [4:0] HALF_DIV8 = 5'h04;
    localparam logic [4:0] HALF_DIV16 = 5'h08;
    localparam logic [4:0] HALF_DIV32 = 5'h10;
    localparam logic [5:0] HALF_DIV64 = 6'h20;
    // Conversion sequence in half periods: 23 halves is 11.5 periods
    localparam logic [4:0] FIRST_TRIAL_CNT = 5'h02;
    localparam logic [4:0] FIRST_DECIDE_CNT = 5'h04;
    localparam logic [3:0] TOP_BIT = 4'h9;
    // Channel codes
    localparam logic [4:0] CH_FIXED = 5'h1F;
    localparam logic [4:0] CH_TEMP = 5'h1D;
    localparam logic [4:0] CH_NEG_REF = 5'h1B;
    localparam logic [4:0] CH_POS_REF = 5'h1A;
    // Positive reference codes
    localparam logic [1:0] PREF_SUPPLY = 2'h0;
    localparam logic [1:0] PREF_PIN = 2'h2;
    localparam logic [1:0] PREF_FIXED = 2'h3;
endpackage
`default_nettype wire

/* core/conv_clock_divider.sv */
// Conversion clock half-period tick generator
`default_nettype none
module conv_clock_divider (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic [2:0] clk_sel,
    input wire logic rc_half_tick,
    output logic half_tick
);
    import adc_pkg::*;

    typedef struct packed {
        logic [5:0] cnt; // Clocks into the current half period
    } div_state_t;

    div_state_t q, d;
    logic [5:0] half_len; // Half period for the selected divider

    ////////////////////////////////////////////////////////////////
    // Divider selection and tick
    always_comb begin
        d = q;
        case (clk_sel)
            3'h0: half_len = {1'b0, HALF_DIV2};
            3'h4: half_len = {1'b0, HALF_DIV4};
            3'h1: half_len = {1'b0, HALF_DIV8};
            3'h5: half_len = {1'b0, HALF_DIV16};
            3'h2: half_len = {1'b0, HALF_DIV32};
            3'h6: half_len = HALF_DIV64;
            default: half_len = 6'h00; // RC oscillator
        endcase
        if (half_len == 6'h00) begin
            half_tick = run & rc_half_tick;
        end else begin
            half_tick = run && (q.cnt == half_len - 6'h01);
        end
        // Counter restarts with each conversion
        if (!run || half_tick || half_len == 6'h00) begin
            d.cnt = 6'h00;
        end else begin
            d.cnt = q.cnt + 6'h01;
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule
`default_nettype wire

/* core/sar_engine.sv */
// Successive-approximation sequencer for a 10-bit result
`default_nettype none
module sar_engine (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic half_tick,
    input wire logic comp_in,
    output logic [9:0] dac_code,
    output logic sampling,
    output logic busy,
    output logic done,
    output logic [9:0] partial
);
    import adc_pkg::*;

    typedef struct packed {
        logic busy;       // Conversion under way
        logic done;       // One-cycle completion pulse
        logic [4:0] cnt;  // Half periods elapsed
        logic [3:0] idx;  // Bit under trial
        logic [9:0] code; // Trial and decided bits
    } sar_state_t;

    sar_state_t q, d;
    logic fill; // Last decided bit, copied downward on abort

    ////////////////////////////////////////////////////////////////
    // Sequencer
    always_comb begin
        d = q;
        d.done = 1'b0;
        if (!run) begin
            // Idle or aborted
            d.busy = 1'b0;
            d.cnt = 5'h00;
            d.idx = TOP_BIT;
            d.code = 10'h000;
        end else if (!q.busy && !q.done) begin
            // Start: sampling for the first 1.5 periods
            d.busy = 1'b1;
            d.cnt = 5'h00;
            d.idx = TOP_BIT;
            d.code = 10'h000;
        end else if (q.busy && half_tick) begin
            d.cnt = q.cnt + 5'h01;
            if (q.cnt == FIRST_TRIAL_CNT) begin
                d.code[TOP_BIT] = 1'b1;
            end else if (q.cnt >= FIRST_DECIDE_CNT && !q.cnt[0]) begin
                // One bit decided per period, last at half 23
                d.code[q.idx] = comp_in;
                if (q.idx == 4'h0) begin
                    d.busy = 1'b0;
                    d.done = 1'b1;
                end else begin
                    d.code[q.idx - 4'h1] = 1'b1;
                    d.idx = q.idx - 4'h1;
                end
            end
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign fill = (q.idx == TOP_BIT) ? 1'b0 : q.code[q.idx + 4'h1];

    // Partial result: undecided bits copy the last decided one
    for (genvar j = 0; j < 10; j++) begin : g_partial
        assign partial[j] = (j > q.idx) ? q.code[j] : fill;
    end

    assign dac_code = q.code;
    assign sampling = q.busy && q.cnt < FIRST_TRIAL_CNT + 5'h01;
    assign busy = q.busy;
    assign done = q.done;
endmodule
`default_nettype wire

/* core/adc_control.sv */
// Converter control block with APB register slave
`default_nettype none
module adc_control (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic trig_compare_unit_one,
    input wire logic trig_compare_unit_two,
    input wire logic trig_timer_zero,
    input wire logic trig_timer_one,
    input wire logic trig_timer_two_period,
    input wire logic rc_half_tick,
    input wire logic comp_in,
    output logic converter_power,
    output logic sample_hold,
    output logic [9:0] dac_code,
    output logic [19:0] analog_input_select,
    output logic fixed_voltage_reference_select,
    output logic temp_indicator_select,
    output logic negative_reference_channel,
    output logic positive_reference_channel,
    output logic ref_supply_select,
    output logic ref_pin_select,
    output logic ref_fixed_select,
    output logic irq
);
    import adc_pkg::*;

    typedef struct packed {
        logic [7:0] chan_run;   // Channel, start and enable
        logic [7:0] fmt_clk;    // Format, clock and reference
        logic [7:0] res_high;   // Result high byte
        logic [7:0] res_low;    // Result low byte
        logic [3:0] trig_ctrl;  // Trigger source and trigger enable
        logic int_status;       // Sticky done flag
        logic int_mask;         // Done flag interrupt mask
        logic irq;              // Interrupt output
        logic [31:0] rdata;     // Read data captured in setup
        logic [19:0] an_sel;    // External input routing
        logic [3:0] int_sel;    // Internal node routing
        logic [2:0] ref_sel;    // Positive reference routing
    } ctl_state_t;

    ctl_state_t q, d;

    logic setup;           // Setup phase of a transfer
    logic access;          // Access phase of a transfer
    logic wr;              // Write taken this cycle
    logic rd;              // Read taken this cycle
    logic mapped;          // Address hits a register
    logic [4:0] chan;      // Current channel code
    logic [4:0] trig_vec;  // Hardware trigger sources
    logic trig_fire;       // Selected trigger fired
    logic [19:0] an_hit;   // Per-input channel match
    logic run;             // Conversion requested and powered
    logic half_tick;       // Half conversion period
    logic eng_busy;        // Engine converting
    logic eng_done;        // Engine finished
    logic [9:0] partial;   // Filled partial result
    logic [15:0] placed;   // Justified result bytes
    logic [9:0] res_src;   // Result to place
    logic load_res;        // Result bytes update
    logic abort;           // Software abort this cycle

    ////////////////////////////////////////////////////////////////
    // Result placement in the two bytes
    function automatic logic [15:0] justify(input logic [9:0] r, input logic right);
        if (right) begin
            justify = {6'h00, r};
        end else begin
            justify = {r, 6'h00};
        end
    endfunction

    ////////////////////////////////////////////////////////////////
    // Bus phases
    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign wr = access & pwrite;
    assign rd = access & ~pwrite;

    // Address map check
    always_comb begin
        if (paddr == OFF_CHAN_RUN) begin
            mapped = 1'b1;
        end else if (paddr == OFF_FMT_CLK) begin
            mapped = 1'b1;
        end else if (paddr == OFF_RES_HIGH) begin
            mapped = 1'b1;
        end else if (paddr == OFF_RES_LOW) begin
            mapped = 1'b1;
        end else if (paddr == OFF_TRIG) begin
            mapped = 1'b1;
        end else if (paddr == OFF_INT_STATUS) begin
            mapped = 1'b1;
        end else if (paddr == OFF_INT_MASK) begin
            mapped = 1'b1;
        end else begin
            mapped = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Channel decode, one match per external input
    assign chan = q.chan_run[CHAN_LSB +: 5];
    for (genvar i = 0; i < 20; i++) begin : g_chan
        if (i <= 4 || i >= 8) begin : g_used
            assign an_hit[i] = (chan == 5'(i));
        end else begin : g_none
            assign an_hit[i] = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Hardware trigger selection
    assign trig_vec = {trig_timer_two_period, trig_timer_one, trig_timer_zero,
                       trig_compare_unit_two, trig_compare_unit_one};
    always_comb begin
        if (q.trig_ctrl[2:0] <= 3'h4) begin
            trig_fire = q.trig_ctrl[TRIG_EN_BIT] & trig_vec[q.trig_ctrl[2:0]];
        end else begin
            trig_fire = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Conversion engine and its clock
    assign run = q.chan_run[GO_BIT] & q.chan_run[EN_BIT];

    conv_clock_divider u_div (
        .pclk(pclk),
        .presetn(presetn),
        .run(eng_busy),
        .clk_sel(q.fmt_clk[CLK_LSB +: 3]),
        .rc_half_tick(rc_half_tick),
        .half_tick(half_tick)
    );

    sar_engine u_sar (
        .pclk(pclk),
        .presetn(presetn),
        .run(run),
        .half_tick(half_tick),
        .comp_in(comp_in),
        .dac_code(dac_code),
        .sampling(sample_hold),
        .busy(eng_busy),
        .done(eng_done),
        .partial(partial)
    );

    ////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        d = q;
        abort = 1'b0;
        load_res = 1'b0;
        res_src = dac_code;

        // Read data captured in the setup phase
        if (setup) begin
            if (paddr == OFF_CHAN_RUN) begin
                d.rdata = {24'h000000, q.chan_run};
            end else if (paddr == OFF_FMT_CLK) begin
                d.rdata = {24'h000000, q.fmt_clk};
            end else if (paddr == OFF_RES_HIGH) begin
                d.rdata = {24'h000000, q.res_high};
            end else if (paddr == OFF_RES_LOW) begin
                d.rdata = {24'h000000, q.res_low};
            end else if (paddr == OFF_TRIG) begin
                d.rdata = {28'h0000000, q.trig_ctrl};
            end else if (paddr == OFF_INT_STATUS) begin
                d.rdata = {31'h00000000, q.int_status};
            end else if (paddr == OFF_INT_MASK) begin
                d.rdata = {31'h00000000, q.int_mask};
            end else begin
                d.rdata = 32'h00000000;
            end
        end

        // Register writes
        if (wr) begin
            if (paddr == OFF_CHAN_RUN) begin
                d.chan_run = pwdata[7:0] & CHAN_RUN_MASK;
                // Clearing the start bit mid-conversion aborts it
                if (eng_busy && !pwdata[GO_BIT]) begin
                    abort = 1'b1;
                end
                // Writing one while busy leaves it running
                if (q.chan_run[GO_BIT] && pwdata[GO_BIT]) begin
                    d.chan_run[GO_BIT] = 1'b1;
                end
            end else if (paddr == OFF_FMT_CLK) begin
                d.fmt_clk = pwdata[7:0] & FMT_CLK_MASK;
            end else if (paddr == OFF_RES_HIGH) begin
                d.res_high = pwdata[7:0];
            end else if (paddr == OFF_RES_LOW) begin
                d.res_low = pwdata[7:0];
            end else if (paddr == OFF_TRIG) begin
                d.trig_ctrl = pwdata[3:0];
            end else if (paddr == OFF_INT_MASK) begin
                d.int_mask = pwdata[0];
            end
        end

        // Reading the status register clears the flag
        if (rd && paddr == OFF_INT_STATUS) begin
            d.int_status = 1'b0;
        end

        // Hardware trigger sets the start bit; it wins over a software clear but not over completion
        if (trig_fire && q.chan_run[EN_BIT]) begin
            d.chan_run[GO_BIT] = 1'b1;
            abort = 1'b0;
        end

        // Abort: partial result loaded, start bit stays clear
        if (abort) begin
            res_src = partial;
            load_res = 1'b1;
        end

        // Completion
        if (eng_done) begin
            d.chan_run[GO_BIT] = 1'b0;
            d.int_status = 1'b1;
            res_src = dac_code;
            load_res = 1'b1;
        end

        // Power removed: start bit cleared; a partial result loads only if the same write cleared start
        if (!d.chan_run[EN_BIT]) begin
            d.chan_run[GO_BIT] = 1'b0;
        end

        // Result loaded in the selected format
        placed = justify(res_src, q.fmt_clk[FMT_BIT]);
        if (load_res) begin
            d.res_high = placed[15:8];
            d.res_low = placed[7:0];
        end

        // Interrupt level
        d.irq = d.int_status & d.int_mask;

        // Input routing
        d.an_sel = an_hit;
        d.int_sel = {chan == CH_FIXED, chan == CH_TEMP,
                     chan == CH_NEG_REF, chan == CH_POS_REF};

        // Positive reference routing; reserved code selects nothing
        d.ref_sel = {q.fmt_clk[1:0] == PREF_FIXED, q.fmt_clk[1:0] == PREF_PIN,
                     q.fmt_clk[1:0] == PREF_SUPPLY};
    end

    ////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
            q.chan_run <= CTRL_RESET;
            q.fmt_clk <= CTRL_RESET;
            q.res_high <= RES_RESET;
            q.res_low <= RES_RESET;
            q.ref_sel <= 3'h1;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Outputs
    assign prdata = q.rdata;
    assign pready = access;
    assign pslverr = access & ~mapped;
    assign converter_power = q.chan_run[EN_BIT];
    assign analog_input_select = q.an_sel;
    assign fixed_voltage_reference_select = q.int_sel[3];
    assign temp_indicator_select = q.int_sel[2];
    assign negative_reference_channel = q.int_sel[1];
    assign positive_reference_channel = q.int_sel[0];
    assign ref_fixed_select = q.ref_sel[2];
    assign ref_pin_select = q.ref_sel[1];
    assign ref_supply_select = q.ref_sel[0];
    assign irq = q.irq;
endmodule
`default_nettype wire

/* bench/adc_control_assertions.sv */
// Port-level concurrent checks for the converter control block
`default_nettype none
module adc_control_checker
    import adc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic converter_power,
    input wire logic sample_hold,
    input wire logic [19:0] analog_input_select,
    input wire logic fixed_voltage_reference_select,
    input wire logic temp_indicator_select,
    input wire logic ref_supply_select,
    input wire logic ref_pin_select,
    input wire logic ref_fixed_select
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Access phase decodes
    wire acc = psel && penable;
    wire wr_chan = acc && pwrite && paddr == OFF_CHAN_RUN;
    wire rd_chan = acc && !pwrite && paddr == OFF_CHAN_RUN;
    wire rd_fmt = acc && !pwrite && paddr == OFF_FMT_CLK;
    AST_POWER_FOLLOWS: assert property (wr_chan |=> converter_power == $past(pwdata[0]))
        else $error("power does not follow enable write");
    AST_NO_SAMPLE_OFF: assert property (!converter_power [*3] |-> !sample_hold)
        else $error("sampling while converter off");
    AST_CHAN_TOP_ZERO: assert property (rd_chan |-> prdata[31:7] == 25'h0000000)
        else $error("unimplemented channel bit reads one");
    AST_FMT_GAP_ZERO: assert property (rd_fmt |-> prdata[3:2] == 2'h0 && prdata[31:8] == 24'h000000)
        else $error("unimplemented format bits read one");
    AST_INPUT_ONEHOT: assert property ($onehot0(analog_input_select) && analog_input_select[7:5] == 3'h0)
        else $error("input routing not one-hot");
    AST_REF_ONEHOT: assert property ($onehot0({ref_supply_select, ref_pin_select, ref_fixed_select}))
        else $error("reference routing not one-hot");
    AST_FIXED_ROUTE: assert property (wr_chan && pwdata[6:2] == 5'h1F |-> ##2 fixed_voltage_reference_select)
        else $error("fixed reference not routed");
    AST_TEMP_ROUTE: assert property (wr_chan && pwdata[6:2] == 5'h1D |-> ##2 temp_indicator_select)
        else $error("temperature node not routed");
    AST_INPUT19_ROUTE: assert property (wr_chan && pwdata[6:2] == 5'h13 |-> ##2 analog_input_select[19])
        else $error("input nineteen not routed");
    AST_UNMAPPED_ERR: assert property (acc && paddr > OFF_INT_MASK |-> pslverr)
        else $error("unmapped access without error");
endmodule
bind adc_control adc_control_checker chk_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr),
    .converter_power(converter_power), .sample_hold(sample_hold), .analog_input_select(analog_input_select),
    .fixed_voltage_reference_select(fixed_voltage_reference_select),
    .temp_indicator_select(temp_indicator_select), .ref_supply_select(ref_supply_select),
    .ref_pin_select(ref_pin_select), .ref_fixed_select(ref_fixed_select));
`default_nettype wire

/* bench/adc_control_tb_top.sv */
// Self-checking bench for the converter control block
`default_nettype none
module adc_control_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import adc_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic rc_tick = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [4:0] trig = 5'h00;
    logic [9:0] aval = 10'h000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, er, irq, power, sh, fixed_voltage_reference, tmp, nref, pref, rsup, rpin, rfix;
    logic [9:0] dac;
    logic [19:0] ain;
    int err_count = 0;
    int checks = 0;
    int base = 2; // Clocks beyond the 23 half periods: flag edge plus the edge that sees irq
    int hv[8] = '{1, 4, 16, 2, 2, 8, 32, 2};
    // Comparator model: analog level against the trial code
    wire comp = aval >= dac;
    always #10 pclk = ~pclk;
    // Free-running RC half-period ticks, one every two clocks
    always @(posedge pclk) rc_tick <= ~rc_tick;
    adc_control uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .trig_compare_unit_one(trig[0]), .trig_compare_unit_two(trig[1]), .trig_timer_zero(trig[2]),
        .trig_timer_one(trig[3]), .trig_timer_two_period(trig[4]), .rc_half_tick(rc_tick), .comp_in(comp),
        .converter_power(power), .sample_hold(sh), .dac_code(dac), .analog_input_select(ain),
        .fixed_voltage_reference_select(fixed_voltage_reference), .temp_indicator_select(tmp), .negative_reference_channel(nref),
        .positive_reference_channel(pref), .ref_supply_select(rsup), .ref_pin_select(rpin),
        .ref_fixed_select(rfix), .irq(irq));
    ////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic hang();
        err_count++;
        $display("ERROR %0t wait ran out", $time);
        wrap_up();
    endtask
    // One APB transfer, entered just after a rising edge; one idle cycle follows
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int i;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        if (i >= 20) hang();
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wait_irq(output int c);
        c = 0;
        while (irq !== 1'b1) begin
            @(posedge pclk);
            c++;
            if (c > 4000) hang();
        end
    endtask
    ////////////////////////////////////////////////////////////
    // Reset values, read-only bits, unmapped address
    task automatic regs();
        for (int a = 0; a <= 24; a += 4) begin
            apb(1'b0, 8'(a), 32'h0);
            chk(rd, 32'h0);
        end
        apb(1'b0, 8'h1C, 32'h0);
        chk(rd, 32'h0);
        chk(er, 1'b1);
        apb(1'b1, OFF_CHAN_RUN, 32'hFD);
        apb(1'b0, OFF_CHAN_RUN, 32'h0);
        chk(rd, 32'h7D);
        chk(power, 1'b1);
        apb(1'b1, OFF_FMT_CLK, 32'hFF);
        apb(1'b0, OFF_FMT_CLK, 32'h0);
        chk(rd, 32'hF3);
        apb(1'b1, OFF_CHAN_RUN, 32'h0);
        chk(power, 1'b0);
    endtask
    // Every channel code and every reference code
    task automatic routes();
        logic [19:0] e;
        for (int k = 0; k < 32; k++) begin
            e = 20'h00000;
            if (k < 5 || (k >= 8 && k < 20)) e[k] = 1'b1;
            apb(1'b1, OFF_CHAN_RUN, 32'(k << 2));
            @(posedge pclk);
            chk(ain, e);
            chk({fixed_voltage_reference, tmp, nref, pref}, {k == 31, k == 29, k == 27, k == 26});
        end
        for (int r = 0; r < 4; r++) begin
            apb(1'b1, OFF_FMT_CLK, 32'(r));
            @(posedge pclk);
            chk({rsup, rpin, rfix}, {r == 0, r == 2, r == 3});
        end
    endtask
    // Masked flag, completion found by polling the start bit
    task automatic masked_poll();
        int i;
        apb(1'b1, OFF_INT_MASK, 32'h0);
        apb(1'b1, OFF_CHAN_RUN, 32'h01);
        apb(1'b1, OFF_CHAN_RUN, 32'h03);
        i = 0;
        do begin
            apb(1'b0, OFF_CHAN_RUN, 32'h0);
            i++;
        end while (rd[1] !== 1'b0 && i < 500);
        if (rd[1] !== 1'b0) hang();
        chk(rd, 32'h01);
        chk(irq, 1'b0);
        apb(1'b0, OFF_INT_STATUS, 32'h0);
        chk(rd, 32'h1);
        apb(1'b1, OFF_INT_MASK, 32'h1);
    endtask
    // Full conversion; result bytes in both formats
    task automatic conv(input logic fmt, input logic [2:0] cs, input logic [9:0] v, output int c);
        aval <= v;
        apb(1'b1, OFF_FMT_CLK, {24'h0, fmt, cs, 4'h0});
        apb(1'b1, OFF_CHAN_RUN, 32'h01);
        apb(1'b1, OFF_CHAN_RUN, 32'h03);
        wait_irq(c);
        apb(1'b0, OFF_INT_STATUS, 32'h0);
        chk(rd, 32'h1);
        apb(1'b0, OFF_CHAN_RUN, 32'h0);
        chk(rd, 32'h01);
        apb(1'b0, OFF_RES_HIGH, 32'h0);
        chk(rd, fmt ? {30'h0, v[9:8]} : {24'h0, v[9:2]});
        apb(1'b0, OFF_RES_LOW, 32'h0);
        chk(rd, fmt ? {24'h0, v[7:0]} : {24'h0, v[1:0], 6'h00});
    endtask
    // Duration for every clock code: base plus 23 half periods of its divider
    task automatic clocks();
        int c;
        for (int i = 0; i < 8; i++) begin
            conv(i[0], 3'(i), 10'h2A5 ^ 10'(i * 65), c);
            chk(i[1:0] == 2'h3 ? (c >= base + 44 && c <= base + 48) : c == base + 23 * hv[i], 1'b1);
        end
    endtask
    // Each trigger source, with a wrong source pulsed first
    task automatic triggers();
        int c;
        for (int s = 0; s < 5; s++) begin
            apb(1'b1, OFF_TRIG, 32'(8 + s));
            trig <= 5'h01 << ((s + 1) % 5);
            @(posedge pclk);
            trig <= 5'h00;
            apb(1'b0, OFF_CHAN_RUN, 32'h0);
            chk(rd, 32'h01);
            trig <= 5'h01 << s;
            @(posedge pclk);
            trig <= 5'h00;
            apb(1'b0, OFF_CHAN_RUN, 32'h0);
            chk(rd, 32'h03);
            wait_irq(c);
            apb(1'b0, OFF_INT_STATUS, 32'h0);
        end
        // Source code above four is refused even with the trigger enabled
        apb(1'b1, OFF_TRIG, 32'hD);
        trig <= 5'h1F;
        @(posedge pclk);
        trig <= 5'h00;
        apb(1'b0, OFF_CHAN_RUN, 32'h0);
        chk(rd, 32'h01);
        apb(1'b1, OFF_TRIG, 32'h0);
    endtask
    // Abort after the top bit is decided: lower bits copy it
    task automatic abort();
        aval <= 10'h2FF;
        apb(1'b1, OFF_FMT_CLK, 32'hE0);
        apb(1'b1, OFF_CHAN_RUN, 32'h03);
        repeat (190) @(posedge pclk);
        apb(1'b1, OFF_CHAN_RUN, 32'h01);
        apb(1'b0, OFF_RES_HIGH, 32'h0);
        chk(rd, 32'h03);
        apb(1'b0, OFF_RES_LOW, 32'h0);
        chk(rd, 32'hFF);
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        regs();
        routes();
        masked_poll();
        clocks();
        triggers();
        abort();
        wrap_up();
    end
endmodule
`default_nettype wire
